/* rtl/pps_map.svh */
// Register offsets, field positions and reset values of the pin input block.
// Assumes a 32-bit classic Wishbone slave; byte addresses, one word each.
`ifndef PPS_MAP_SVH
`define PPS_MAP_SVH

// ==========================================================
// Geometry
`define PPS_PINS 8
`define PPS_AW 5

// ==========================================================
// Register byte offsets
`define PPS_DIR_OFF 5'h00
`define PPS_OUT_OFF 5'h04
`define PPS_IN_OFF 5'h08
`define PPS_CTRL_OFF 5'h0c
`define PPS_EXTEN_OFF 5'h10
`define PPS_EXTFLAG_OFF 5'h14

// ==========================================================
// Control register fields
`define PPS_CTRL_PUD_BIT 0
`define PPS_CTRL_SENSE_LO 1
`define PPS_CTRL_SENSE_HI 2

// ==========================================================
// Reset values
`define PPS_PINS_RST 8'h00
`define PPS_SENSE_RST 2'h0

`endif

/* rtl/pps_pkg.sv */
// Types shared by the pin input block and its surroundings.
// Assumes pps_map.svh is included before this package is compiled.
`include "pps_map.svh"

package pps_pkg;

    // ==========================================================
    // Pin vector
    typedef logic [`PPS_PINS-1:0] pps_pins_t;

    // Interrupt sense modes
    typedef enum logic [1:0] {
        PPS_SENSE_LOW,
        PPS_SENSE_ANY,
        PPS_SENSE_FALL,
        PPS_SENSE_RISE
    } pps_sense_t;

    // Alternate function override bundle, one bit per pin
    typedef struct packed {
        pps_pins_t pullup_override_en;
        pps_pins_t pullup_override_val;
        pps_pins_t dir_override_en;
        pps_pins_t dir_override_val;
        pps_pins_t value_override_en;
        pps_pins_t value_override_val;
        pps_pins_t input_enable_override_en;
        pps_pins_t input_enable_override_val;
        pps_pins_t alt_in_use;
    } pps_alt_t;

    // Pad side of the pins
    typedef struct packed {
        pps_pins_t pad_out;
        pps_pins_t pad_oe_n;
        pps_pins_t pullup_en;
    } pps_pad_t;

endpackage : pps_pkg

/* rtl/pps_top.sv */
// Input path of one general-purpose port: synchroniser, sleep clamp,
// overrides, edge flags and a classic Wishbone register slave.
// Assumes pads on the far side, sleep and alternate controls on clock.
//
// Chosen here: the Wishbone slave port and the placing of the registers.
`timescale 1ns/10ps
`include "pps_map.svh"

module pps_top (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [`PPS_AW-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Pad side
    input wire pps_pkg::pps_pins_t pad_in,
    output pps_pkg::pps_pad_t pad,
    // Sleep controller and alternate functions
    input wire logic sleep_deep,
    input wire pps_pkg::pps_alt_t alt,
    output pps_pkg::pps_pins_t alt_input_tap,
    // Flags toward the interrupt controller
    output pps_pkg::pps_pins_t ext_flag
);

    // ==========================================================
    // Register state
    pps_pkg::pps_pins_t output_drive_select_reg; // Direction, 1 = drive
    pps_pkg::pps_pins_t output_latch_bit_reg; // Drive value or pull-up
    pps_pkg::pps_pins_t output_latch_bit_next;
    pps_pkg::pps_pins_t ext_enable_reg; // External request enables
    pps_pkg::pps_pins_t ext_flag_reg; // Sticky edge flags
    pps_pkg::pps_pins_t ext_flag_next;
    pps_pkg::pps_sense_t sense_reg; // Shared sense mode
    logic pullup_disable_reg; // Global pull-up kill
    logic ack_reg;
    logic [31:0] rdata_reg;
    pps_pkg::pps_pad_t pad_reg;
    pps_pkg::pps_pad_t pad_next;

    // ==========================================================
    // Synchroniser state
    pps_pkg::pps_pins_t sync_latch; // Transparent while clock high
    pps_pkg::pps_pins_t pin_input_bit_reg; // Second stage, software view
    pps_pkg::pps_pins_t pin_prev_reg; // Previous sample for edges

    // ==========================================================
    // Bus decode
    wire logic bus_req = wb_cyc_i & wb_stb_i;
    // Writes land at the edge where ack is high, as the master samples it
    wire logic wr_now = bus_req & wb_we_i & ack_reg & wb_sel_i[0];
    wire logic hit_dir = (wb_adr_i == `PPS_DIR_OFF);
    wire logic hit_out = (wb_adr_i == `PPS_OUT_OFF);
    wire logic hit_in = (wb_adr_i == `PPS_IN_OFF);
    wire logic hit_ctrl = (wb_adr_i == `PPS_CTRL_OFF);
    wire logic hit_exten = (wb_adr_i == `PPS_EXTEN_OFF);
    wire logic hit_flag = (wb_adr_i == `PPS_EXTFLAG_OFF);
    wire pps_pkg::pps_pins_t wr_pins = wb_dat_i[`PPS_PINS-1:0];

    // ==========================================================
    // Digital input enable
    // Clamp is released for enabled interrupts and active alternates
    // Enabled interrupt releases
    wire pps_pkg::pps_pins_t sleep_release = ext_enable_reg | alt.alt_in_use;
    wire pps_pkg::pps_pins_t sleep_enable =
        sleep_deep ? sleep_release : {`PPS_PINS{1'b1}};
    wire pps_pkg::pps_pins_t input_enable =
        (alt.input_enable_override_en & alt.input_enable_override_val) |
        (~alt.input_enable_override_en & sleep_enable);
    // Clamped value, models the Schmitt trigger output
    wire pps_pkg::pps_pins_t schmitt_out = pad_in & input_enable;

    // Tap before synchroniser
    // Alternates resync themselves; this tap is deliberately unregistered
    assign alt_input_tap = schmitt_out;

    // ==========================================================
    // Two-stage synchroniser, latch then flop
    // Latch open on high clock
    // Clear latch on reset
    // Non-blocking, so the rising-edge flop still takes the value held
    // while the clock was low and never races the latch opening
    always_latch begin
        if (!reset_n) begin
            sync_latch <= `PPS_PINS_RST;
        end else if (clock) begin
            sync_latch <= schmitt_out;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pin_input_bit_reg <= `PPS_PINS_RST;
            pin_prev_reg <= `PPS_PINS_RST;
        end else begin
            pin_input_bit_reg <= sync_latch;
            pin_prev_reg <= pin_input_bit_reg;
        end
    end

    // ==========================================================
    // Edge detection on the synchronised value
    wire pps_pkg::pps_pins_t rise = pin_input_bit_reg & ~pin_prev_reg;
    wire pps_pkg::pps_pins_t fall = ~pin_input_bit_reg & pin_prev_reg;

    // Sense mode selection, used for every pin
    function automatic pps_pkg::pps_pins_t sense_hit(
        input pps_pkg::pps_sense_t mode,
        input pps_pkg::pps_pins_t r,
        input pps_pkg::pps_pins_t f,
        input pps_pkg::pps_pins_t lvl,
        input pps_pkg::pps_pins_t en
    );
        case (mode)
            // Low level only requests while enabled
            pps_pkg::PPS_SENSE_LOW: sense_hit = ~lvl & en;
            pps_pkg::PPS_SENSE_ANY: sense_hit = r | f;
            pps_pkg::PPS_SENSE_FALL: sense_hit = f;
            default: sense_hit = r;
        endcase
    endfunction

    // Edge modes set flags regardless of enable; low level needs it
    // Clamp release of a high pin makes a rising edge here, so it flags in the rise and any modes
    wire pps_pkg::pps_pins_t flag_set =
        sense_hit(sense_reg, rise, fall, pin_input_bit_reg, ext_enable_reg);
    wire pps_pkg::pps_pins_t flag_clr =
        (wr_now && hit_flag) ? wr_pins : {`PPS_PINS{1'b0}};
    // Set wins over a write-one-to-clear in the same cycle
    assign ext_flag_next = flag_set | (ext_flag_reg & ~flag_clr);

    // ==========================================================
    // Output latch next value
    // Write to input register toggles the latch bits written as one
    always_comb begin
        output_latch_bit_next = output_latch_bit_reg;
        if (wr_now && hit_out) begin
            output_latch_bit_next = wr_pins;
        end else if (wr_now && hit_in) begin
            output_latch_bit_next = output_latch_bit_reg ^ wr_pins;
        end
    end

    // ==========================================================
    // Pad control with alternate overrides
    // Overrides on pin control
    // Pad follows latch same edge
    // Built from next values so a direction or latch write reaches the pad without delay
    always_comb begin
        pps_pkg::pps_pins_t dir_n;
        pps_pkg::pps_pins_t dd_eff;
        pps_pkg::pps_pins_t pu_gen;
        dir_n = (wr_now && hit_dir) ? wr_pins : output_drive_select_reg;
        dd_eff = (alt.dir_override_en & alt.dir_override_val) |
                 (~alt.dir_override_en & dir_n);
        pu_gen = ~dir_n & output_latch_bit_next &
                 {`PPS_PINS{~pullup_disable_reg}};
        pad_next.pad_oe_n = ~dd_eff;
        pad_next.pad_out = (alt.value_override_en & alt.value_override_val) |
                           (~alt.value_override_en & output_latch_bit_next);
        pad_next.pullup_en = (alt.pullup_override_en & alt.pullup_override_val) |
                             (~alt.pullup_override_en & pu_gen);
    end

    // ==========================================================
    // Read data select
    // Input readable any direction
    wire logic [31:0] rd_mux =
        hit_dir ? {{(32-`PPS_PINS){1'b0}}, output_drive_select_reg} :
        hit_out ? {{(32-`PPS_PINS){1'b0}}, output_latch_bit_reg} :
        hit_in ? {{(32-`PPS_PINS){1'b0}}, pin_input_bit_reg} :
        hit_ctrl ? {29'h0000000, sense_reg, pullup_disable_reg} :
        hit_exten ? {{(32-`PPS_PINS){1'b0}}, ext_enable_reg} :
        hit_flag ? {{(32-`PPS_PINS){1'b0}}, ext_flag_reg} :
        32'h00000000;

    // ==========================================================
    // Bus handshake, one wait state; unmapped reads answer zero
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ack_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
        end else begin
            ack_reg <= bus_req & ~ack_reg;
            rdata_reg <= rd_mux;
        end
    end

    // ==========================================================
    // Control registers
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            output_drive_select_reg <= `PPS_PINS_RST;
            ext_enable_reg <= `PPS_PINS_RST;
            sense_reg <= pps_pkg::PPS_SENSE_LOW;
            pullup_disable_reg <= 1'b0;
        end else if (wr_now) begin
            if (hit_dir) begin
                output_drive_select_reg <= wr_pins;
            end else if (hit_exten) begin
                ext_enable_reg <= wr_pins;
            end else if (hit_ctrl) begin
                sense_reg <= pps_pkg::pps_sense_t'(
                    wb_dat_i[`PPS_CTRL_SENSE_HI:`PPS_CTRL_SENSE_LO]);
                pullup_disable_reg <= wb_dat_i[`PPS_CTRL_PUD_BIT];
            end
        end
    end

    // ==========================================================
    // Latch, flags and pads
    // Pull-up off in reset
    // Reset loads pad_oe_n high and the other pad flops low, so pins float with no pull-up
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            output_latch_bit_reg <= `PPS_PINS_RST;
            ext_flag_reg <= `PPS_PINS_RST;
            pad_reg <= '{pad_out: '0, pad_oe_n: '1, pullup_en: '0};
        end else begin
            output_latch_bit_reg <= output_latch_bit_next;
            ext_flag_reg <= ext_flag_next;
            pad_reg <= pad_next;
        end
    end

    // ==========================================================
    // Outputs from flops
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdata_reg;
    assign pad = pad_reg;
    assign ext_flag = ext_flag_reg;

endmodule // pps_top

/* tb/pps_top_props.sv */
// Checker for the pin input block, watching the top module's ports only.
// Assumes pps_pkg is compiled first; bound to every pps_top instance.
`timescale 1ns/10ps

module pps_props_chk (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Bus handshake
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    // Pins, sleep and overrides
    input wire pps_pkg::pps_pins_t pad_in,
    input wire pps_pkg::pps_pad_t pad,
    input wire logic sleep_deep,
    input wire pps_pkg::pps_alt_t alt,
    input wire pps_pkg::pps_pins_t alt_input_tap,
    input wire pps_pkg::pps_pins_t ext_flag
);
    // ==========================================================
    // One domain, so clock and reset are given once
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    tap_pass_a: assert property (!sleep_deep |-> ((alt_input_tap ^ pad_in)
        & ~alt.input_enable_override_en) == 0) else $error("tap differs from pad");
    tap_override_a: assert property (((alt_input_tap ^ (pad_in
        & alt.input_enable_override_val)) & alt.input_enable_override_en) == 0)
        else $error("tap ignores input override");
    tap_alt_a: assert property (((alt_input_tap ^ pad_in) & alt.alt_in_use
        & ~alt.input_enable_override_en) == 0) else $error("alternate pin clamped");
    reset_pad_a: assert property ($rose(reset_n) |-> pad.pullup_en == 0
        && ext_flag == 0) else $error("pads not cleared by reset");
    ack_timing_a: assert property ($rose(wb_cyc_i && wb_stb_i) |=> wb_ack_o)
        else $error("ack not one cycle after request");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
    flag_sticky_a: assert property (!(wb_cyc_i && wb_stb_i) |=>
        ($past(ext_flag) & ~ext_flag) == 0) else $error("flag dropped without write");
    dir_override_a: assert property ($past(reset_n) |-> (pad.pad_oe_n
        & $past(alt.dir_override_en)) == (~$past(alt.dir_override_val)
        & $past(alt.dir_override_en))) else $error("direction override lost");
    pullup_override_a: assert property ($past(reset_n) |-> (pad.pullup_en
        & $past(alt.pullup_override_en)) == ($past(alt.pullup_override_val)
        & $past(alt.pullup_override_en))) else $error("pull-up override lost");
endmodule // pps_props_chk

bind pps_top pps_props_chk pps_props_chk_inst (.clock(clock), .reset_n(reset_n),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .pad_in(pad_in),
    .pad(pad), .sleep_deep(sleep_deep), .alt(alt), .alt_input_tap(alt_input_tap),
    .ext_flag(ext_flag));

/* tb/pps_pad_model.sv */
// Pad model: device driver, pull-up, outside drive or a wandering level.
// Assumes the bench sets the outside drive mask and level.
`timescale 1ns/10ps

module pps_pad_model (
    // Clock for the floating pattern
    input wire logic clock,
    // Device and outside drivers
    input wire pps_pkg::pps_pad_t pad,
    input wire pps_pkg::pps_pins_t ext_en,
    input wire pps_pkg::pps_pins_t ext_val,
    // Level seen by the device
    output pps_pkg::pps_pins_t pad_in
);
    // Undriven pins wander, so a stale value never passes
    pps_pkg::pps_pins_t float_reg = 8'h5a;
    always @(posedge clock) float_reg <= ~float_reg;
    assign pad_in = (~pad.pad_oe_n & pad.pad_out) | (pad.pad_oe_n & ext_en & ext_val)
        | (pad.pad_oe_n & ~ext_en & (pad.pullup_en | float_reg));
endmodule // pps_pad_model

/* tb/port_pin_input_sync_test.sv */
// Bench for the pin input block: bus tasks and scripted pin scenarios.
// Assumes the pad model on the pins and the bound checker.
`timescale 1ns/10ps
`include "pps_map.svh"

module port_pin_input_sync_test;
    // ==========================================================
    // Signals
    logic clock = 1'b0, reset_n = 1'b0, sleep_deep = 1'b0;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
    logic [`PPS_AW-1:0] wb_adr_i = 5'h00;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
    pps_pkg::pps_pins_t pad_in, alt_input_tap, ext_flag, ext_en = 8'hff, ext_val = 8'h3c;
    pps_pkg::pps_pad_t pad;
    pps_pkg::pps_alt_t alt = '0;
    int err_count = 0, checks = 0, cycle_count = 0;

    always #2 clock = ~clock;
    pps_top pps_top_inst (.clock(clock), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pad_in(pad_in),
        .pad(pad), .sleep_deep(sleep_deep), .alt(alt), .alt_input_tap(alt_input_tap),
        .ext_flag(ext_flag));
    pps_pad_model pps_pad_model_inst (.clock(clock), .pad(pad), .ext_en(ext_en),
        .ext_val(ext_val), .pad_in(pad_in));

    // ==========================================================
    // Tasks
    // One classic cycle; request held until ack is sampled high
    task automatic bus(input logic [`PPS_AW-1:0] a, input logic we, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge clock);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (n >= 20) err_count++;
    endtask
    task automatic check_word(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
            err_count++;
        end
    endtask
    task automatic check_pins(input string nm, input pps_pkg::pps_pins_t e,
        input pps_pkg::pps_pins_t g);
        check_word(nm, {24'h0, e}, {24'h0, g});
    endtask
    task automatic rd_check(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e,
        input string nm);
        bus(a, 1'b0, 32'h0);
        check_word(nm, e, rd & m);
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Hang guard, far above the scripted run length
    always @(posedge clock) begin
        cycle_count <= cycle_count + 1;
        if (cycle_count == 2000) begin
            err_count++;
            complete_run();
        end
    end

    // ==========================================================
    // Scenarios
    initial begin
        repeat (8) @(posedge clock);
        reset_n <= 1'b1;
        rd_check(`PPS_DIR_OFF, 32'hff, 32'h0, "dir reset");
        rd_check(5'h18, 32'hffffffff, 32'h0, "unmapped read");
        $display("test reset done");
        bus(`PPS_DIR_OFF, 1'b1, 32'h0f);
        bus(`PPS_OUT_OFF, 1'b1, 32'ha5);
        rd_check(`PPS_IN_OFF, 32'hff, 32'h35, "in mixed");
        check_pins("pullup", 8'ha0, pad.pullup_en);
        check_pins("drive", 8'hf0, pad.pad_oe_n);
        check_pins("pad out", 8'ha5, pad.pad_out);
        bus(`PPS_IN_OFF, 1'b1, 32'h0f);
        rd_check(`PPS_OUT_OFF, 32'hff, 32'haa, "out toggled");
        bus(`PPS_IN_OFF, 1'b1, 32'h0f);
        rd_check(`PPS_OUT_OFF, 32'hff, 32'ha5, "out restored");
        ext_en <= 8'h00;
        rd_check(`PPS_IN_OFF, 32'haf, 32'ha5, "in pulled");
        reset_n <= 1'b0;
        @(posedge clock);
        check_pins("pullup in reset", 8'h00, pad.pullup_en);
        reset_n <= 1'b1;
        ext_en <= 8'hff;
        $display("test readback done");
        ext_val <= 8'hc3;
        rd_check(`PPS_IN_OFF, 32'hff, 32'hc3, "in latency");
        ext_val <= 8'hff;
        bus(`PPS_EXTEN_OFF, 1'b1, 32'h03);
        alt.alt_in_use <= 8'h0c;
        alt.input_enable_override_en <= 8'h30;
        alt.input_enable_override_val <= 8'h10;
        alt.pullup_override_en <= 8'h01;
        alt.dir_override_en <= 8'h80;
        sleep_deep <= 1'b1;
        rd_check(`PPS_IN_OFF, 32'hff, 32'h1f, "in asleep");
        check_pins("tap asleep", 8'h1f, alt_input_tap);
        sleep_deep <= 1'b0;
        rd_check(`PPS_IN_OFF, 32'hff, 32'hdf, "in awake");
        $display("test sleep done");
        alt <= '0;
        bus(`PPS_EXTEN_OFF, 1'b1, 32'h00);
        bus(`PPS_CTRL_OFF, 1'b1, 32'h06);
        bus(`PPS_EXTFLAG_OFF, 1'b1, 32'hff);
        sleep_deep <= 1'b1;
        repeat (3) @(posedge clock);
        sleep_deep <= 1'b0;
        repeat (4) @(posedge clock);
        check_pins("flags on wake", 8'hff, ext_flag);
        bus(`PPS_EXTFLAG_OFF, 1'b1, 32'hff);
        rd_check(`PPS_EXTFLAG_OFF, 32'hff, 32'h0, "flags cleared");
        $display("test wake flags done");
        complete_run();
    end
endmodule // port_pin_input_sync_test
